// >>> rpg_pkg.sv
// package for the rail power-good status bank
package rpg_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] OFF_STATUS = 8'h0f;
  localparam logic [7:0] OFF_REVISION = 8'h10;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h40;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h41;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam int BIT_BOOST = 7;
  localparam int BIT_GATE_HIGH = 6;
  localparam int BIT_INVERTER = 5;
  localparam int BIT_POS_SOURCE = 4;
  localparam int BIT_GATE_LOW = 3;
  localparam int BIT_NEG_SOURCE = 1;
  localparam logic [7:0] STATUS_USED = 8'hfa;
  localparam logic [7:0] PANEL_RAILS = 8'h5a;
  localparam int MAJOR_LSB = 6;
  localparam int MINOR_LSB = 4;
  localparam int NUM_RAILS = 6;
  // arbitrary neutral revision value
  localparam logic [7:0] REVISION_DEFAULT = 8'h11;

  typedef struct packed {
    logic boost_good_flag;
    logic gate_high_pump_good;
    logic inverter_good_flag;
    logic pos_source_reg_good;
    logic gate_low_pump_good;
    logic neg_source_reg_good;
  } rpg_rails_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } rpg_bus_t;
endpackage

// >>> rpg_sync.sv
// two-stage resynchroniser for the rail regulation levels
`timescale 1ns/1ps
module rpg_sync #(
  parameter int WIDTH = 6
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage1;

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (!resetn) begin
      stage1 <= '0;
      dout <= '0;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule

// >>> rpg_bank.sv
// rail power-good status bank with register port and open-drain power-ok pin
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
// Notes on behaviour
// - bit 7 is 1 while the boost converter regulates, else 0.
// - bit 6 is 1 while the positive gate pump regulates, else 0.
// - bit 5 is 1 while the inverting converter regulates, else 0.
// - bit 4 is 1 while the positive source regulator regulates, else 0.
// - bit 3 is 1 while the negative gate pump regulates, else 0.
// - bit 1 follows the negative source regulator; bits 2 and 0 read 0.
// - power-ok pin released only when all four panel rail bits are 1.
module rpg_bank
  import rpg_pkg::*;
#(
  parameter logic [7:0] REVISION = rpg_pkg::REVISION_DEFAULT
) (
  input wire logic clk,
  input wire logic resetn,
  input wire rpg_pkg::rpg_rails_t rails_in,
  input wire logic [rpg_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [rpg_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [rpg_pkg::DATA_W-1:0] reg_rdata,
  output logic power_ok_output_o,
  output logic power_ok_output_oe,
  output logic irq
);
  import rpg_pkg::*;

  rpg_rails_t rails_sync;
  logic [7:0] status;
  logic [7:0] prev_status;
  logic [7:0] irq_status;
  logic [7:0] irq_mask;
  logic [7:0] next_status;
  logic [7:0] changed;

  // map a rail struct onto the register layout
  function automatic logic [7:0] rail_bits(input rpg_rails_t r);
    logic [7:0] b;
    b = 8'h00;
    b[BIT_BOOST] = r.boost_good_flag;
    b[BIT_GATE_HIGH] = r.gate_high_pump_good;
    b[BIT_INVERTER] = r.inverter_good_flag;
    b[BIT_POS_SOURCE] = r.pos_source_reg_good;
    b[BIT_GATE_LOW] = r.gate_low_pump_good;
    b[BIT_NEG_SOURCE] = r.neg_source_reg_good;
    return b;
  endfunction

  // rail detector levels come from the analog side, so resample them
  rpg_sync #(
    .WIDTH(NUM_RAILS)
  ) u_sync (
    .clk(clk),
    .resetn(resetn),
    .din(rails_in),
    .dout(rails_sync)
  );

  // follow the rails; unused bits forced low
  assign next_status = rail_bits(rails_sync) & STATUS_USED;

  // status register tracks regulation; bus writes never touch it
  always_ff @(posedge clk) begin
    if (!resetn) begin
      status <= STATUS_RESET;
      prev_status <= STATUS_RESET;
    end else begin
      status <= next_status;
      prev_status <= status;
    end
  end

  // any good bit that toggles is an event
  assign changed = (status ^ prev_status) & STATUS_USED;

  // sticky events; a new event wins over a write-one clear in the same cycle
  always_ff @(posedge clk) begin
    if (!resetn) begin
      irq_status <= 8'h00;
    end else if (reg_wr && reg_addr == OFF_IRQ_STATUS) begin
      irq_status <= (irq_status & ~reg_wdata) | changed;
    end else begin
      irq_status <= irq_status | changed;
    end
  end

  // mask register, one enable per status bit
  always_ff @(posedge clk) begin
    if (!resetn) begin
      irq_mask <= MASK_RESET;
    end else if (reg_wr && reg_addr == OFF_IRQ_MASK) begin
      irq_mask <= reg_wdata & STATUS_USED;
    end
  end

  // level interrupt, registered
  always_ff @(posedge clk) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  // open-drain pin
  // drive low unless every panel rail is good; register keeps the pin glitch free
  always_ff @(posedge clk) begin
    if (!resetn) begin
      power_ok_output_oe <= 1'b1;
      power_ok_output_o <= 1'b0;
    end else begin
      power_ok_output_oe <= (next_status & PANEL_RAILS) != PANEL_RAILS;
      power_ok_output_o <= 1'b0;
    end
  end

  // side-effect-free reads
  // read data valid the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        OFF_STATUS: reg_rdata <= status;
        OFF_REVISION: reg_rdata <= REVISION;
        OFF_IRQ_STATUS: reg_rdata <= irq_status;
        OFF_IRQ_MASK: reg_rdata <= irq_mask;
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule

// >>> rpg_chk_sva.sv
// port assertions for the rail power-good bank
`timescale 1ns/1ps
module rpg_chk
  import rpg_pkg::*;
#(parameter logic [7:0] REVISION = REVISION_DEFAULT) (
  input wire logic clk,
  input wire logic resetn,
  input wire rpg_pkg::rpg_rails_t rails_in,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic power_ok_output_o,
  input wire logic power_ok_output_oe
);
  logic [7:0] st;
  // status image the rails should give; bits 2 and 0 stay 0
  assign st = {rails_in[5:1], 1'b0, rails_in[0], 1'b0};
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // five settled edges cover the resync pipeline
  sequence s;
    $stable(rails_in)[*5] ##0 (reg_rd && reg_addr == 8'h0f);
  endsequence
  property p_b7; s |=> reg_rdata[7] == $past(st[7]); endproperty
  a_b7: assert property (p_b7) else $error("b7");
  property p_b6; s |=> reg_rdata[6] == $past(st[6]); endproperty
  a_b6: assert property (p_b6) else $error("b6");
  property p_b5; s |=> reg_rdata[5] == $past(st[5]); endproperty
  a_b5: assert property (p_b5) else $error("b5");
  property p_b4; s |=> reg_rdata[4] == $past(st[4]); endproperty
  a_b4: assert property (p_b4) else $error("b4");
  property p_b3; s |=> reg_rdata[3] == $past(st[3]); endproperty
  a_b3: assert property (p_b3) else $error("b3");
  property p_b1; s |=> reg_rdata[2:0] == $past(st[2:0]); endproperty
  a_b1: assert property (p_b1) else $error("b2 to b0");
  property p_pin; $stable(rails_in)[*5] |->
    !power_ok_output_o && power_ok_output_oe == ~&{st[6], st[4:3], st[1]}; endproperty
  a_pin: assert property (p_pin) else $error("pin");
  property p_rev; reg_rd && reg_addr == 8'h10 |=> reg_rdata == REVISION; endproperty
  a_rev: assert property (p_rev) else $error("rev");
endmodule
bind rpg_bank rpg_chk #(.REVISION(REVISION)) i_rpg_chk (.*);

// >>> testbench.sv
// self-checking bench for the rail power-good bank
`timescale 1ns/1ps
module testbench;
  import rpg_pkg::*;
  logic clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  rpg_rails_t rails_in = '0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d;
  logic power_ok_output_o, power_ok_output_oe, irq;
  int miscompares = 0, comparisons = 0;
  rpg_bank i_rpg_bank (.*);
  always #5 clk = ~clk;
  task automatic chk(string n, logic [7:0] e, logic [7:0] s);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  // one-cycle strobe; read data is taken in the cycle after
  task automatic bus(logic w, logic [7:0] a, logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // six edges let status, event and irq settle
  task automatic rails(logic [5:0] v);
    @(posedge clk);
    rails_in <= v;
    repeat (6) @(posedge clk);
    #1;
  endtask
  task automatic t_rails();
    logic [5:0] v;
    bus(0, OFF_STATUS, 8'h00);
    chk("rst", STATUS_RESET, d);
    for (int i = 0; i < 8; i++) begin
      v = i < 6 ? 6'(1 << i) : (i == 6 ? 6'h17 : 6'h3f);
      rails(v);
      bus(0, OFF_STATUS, 8'h00);
      chk("st", {v[5:1], 1'b0, v[0], 1'b0}, d);
      chk("oe", 8'(~&{v[4], v[2:0]}), 8'(power_ok_output_oe));
      chk("o", 8'h00, 8'(power_ok_output_o));
    end
  endtask
  task automatic t_ro();
    bus(1, OFF_STATUS, 8'h00);
    bus(1, OFF_REVISION, 8'h00);
    bus(0, OFF_STATUS, 8'h00);
    chk("st", 8'hfa, d);
    chk("oe", 8'h00, 8'(power_ok_output_oe));
    bus(0, OFF_REVISION, 8'h00);
    chk("rev", REVISION_DEFAULT, d);
    bus(0, 8'h20, 8'h00);
    chk("unmapped", 8'h00, d);
    // read data stands one cycle only, then returns to zero
    bus(0, OFF_STATUS, 8'h00);
    @(posedge clk);
    #1 chk("rdata_idle", 8'h00, reg_rdata);
  endtask
  // only the boost event is unmasked
  task automatic t_irq();
    bus(1, OFF_IRQ_STATUS, 8'hff);
    bus(1, OFF_IRQ_MASK, 8'h80);
    rails(6'h1f);
    chk("irq", 8'h01, 8'(irq));
    bus(1, OFF_IRQ_STATUS, 8'h80);
    rails(6'h1e);
    chk("irq", 8'h00, 8'(irq));
  endtask
  task automatic complete_run();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    t_rails();
    t_ro();
    t_irq();
    complete_run();
  end
endmodule
